// ===== rtl/system_irq_router_pkg.sv
// Purpose: Shared constants and types for the system interrupt router and core event control.
// Assumes: One clock domain; peripheral sources are synchronous single-bit levels.
// Notes:   Source-to-ID and ID-to-level defaults live here as constant tables.
`default_nettype none
package system_irq_router_pkg;
   // Sizes of the source, ID, level and general-purpose spaces.
   localparam int SRC_COUNT   = 42;
   localparam int ID_COUNT    = 29;
   localparam int GP_COUNT    = 9;
   localparam int LEVEL_COUNT = 16;
   localparam int GP_BASE     = 7;
   // Event level positions inside the sixteen-level vector.
   localparam int LVL_EMULATION = 0;
   localparam int LVL_RST     = 1;
   localparam int LVL_NMI     = 2;
   localparam int LVL_EXC     = 3;
   localparam int LVL_RSV     = 4;
   localparam int LVL_HWERR   = 5;
   localparam int LVL_CTMR    = 6;
   // Levels below this one cannot be masked.
   localparam int LVL_MASKABLE = 5;
   // Index of the generic DMA error source, first member of shared ID 1.
   localparam int SRC_DMA_ERR = 1;

   typedef logic [4:0] irq_id_t;    // Peripheral interrupt ID.
   typedef logic [3:0] gp_sel_t;    // Routed level, 0 means level 7, 8 means level 15.
   typedef logic [3:0] level_t;     // Core event level number.

   // Highest legal routing code, general-purpose level 15.
   localparam gp_sel_t GP_SEL_MAX = 4'h8;

   // Interrupt ID carried by each peripheral source, index is the source number.
   localparam irq_id_t SRC_ID [SRC_COUNT] = '{
      5'h00,                                     // PLL wakeup.
      5'h01, 5'h01, 5'h01, 5'h01, 5'h01,         // DMA error, memory DMA done and overflow.
      5'h02, 5'h02, 5'h02, 5'h02,                // CAN, MAC, serial port 0 and 1 errors.
      5'h02, 5'h02, 5'h02, 5'h02,                // Parallel port, SPI, UART0, UART1 errors.
      5'h03, 5'h04,                              // RTC, parallel port DMA.
      5'h05, 5'h06, 5'h07, 5'h08,                // Serial port DMA channels.
      5'h09, 5'h0A,                              // Two-wire interface, SPI DMA.
      5'h0B, 5'h0C, 5'h0D, 5'h0E,                // UART DMA channels.
      5'h0F, 5'h10,                              // CAN receive and transmit.
      5'h11, 5'h11, 5'h12, 5'h12,                // MAC DMA shared with port H A and B.
      5'h13, 5'h14, 5'h15, 5'h16,                // Timers 0 to 3.
      5'h17, 5'h18, 5'h19, 5'h1A,                // Timers 4 to 7.
      5'h1B, 5'h1C                               // Port F/G A, port G B.
   };

   // Routing applied after reset, index is the interrupt ID.
   localparam gp_sel_t DFLT_ROUTE [ID_COUNT] = '{
      4'h0, 4'h0, 4'h0,                          // IDs 0 to 2 on level 7.
      4'h1, 4'h1,                                // IDs 3 and 4 on level 8.
      4'h2, 4'h2, 4'h2, 4'h2,                    // IDs 5 to 8 on level 9.
      4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3,        // IDs 9 to 14 on level 10.
      4'h4, 4'h4, 4'h4, 4'h4,                    // IDs 15 to 18 on level 11.
      4'h5, 4'h5, 4'h5, 4'h5, 4'h5,              // IDs 19 to 23 on level 12.
      4'h5, 4'h5, 4'h5, 4'h5, 4'h5               // IDs 24 to 28 on level 12.
   };
endpackage : system_irq_router_pkg
`default_nettype wire

// ===== rtl/core_event_if.sv
// Purpose: Carries the routed requests and fixed events into the core event control.
// Assumes: All signals belong to the single system clock.
// Notes:   The router side drives requests; the controller side returns its verdict.
`default_nettype none
interface core_event_if;
   import system_irq_router_pkg::*;
   logic [GP_COUNT-1:0]    gp_req;     // Routed general-purpose requests, level 7 in bit 0.
   logic [LVL_MASKABLE+1:0] fixed_ev;  // Fixed events at levels 0 to 6, bit 4 unused.
   logic [LEVEL_COUNT-1:0] mask;       // Enable per maskable level.
   logic [LEVEL_COUNT-1:0] pending;    // Enabled pending levels.
   logic                   valid;      // Some level pends.
   level_t                 top_level;  // Highest priority pending level.

   modport router (output gp_req, output fixed_ev, output mask,
                   input pending, input valid, input top_level);
   modport ctrl   (input gp_req, input fixed_ev, input mask,
                   output pending, output valid, output top_level);
endinterface : core_event_if
`default_nettype wire

// ===== rtl/core_event_ctrl.sv
// Purpose: Orders the sixteen core event levels and picks the highest pending one.
// Assumes: Inputs are synchronous levels; mask bits below level 5 are ignored.
// Notes:   One cycle from request to verdict; all outputs are registered.
`default_nettype none
module core_event_ctrl (
   input  wire logic  clk,
   input  wire logic  rst_b,
   core_event_if.ctrl ev
);
   import system_irq_router_pkg::*;

   logic [LEVEL_COUNT-1:0] pend_r;   // Registered pending levels.
   logic [LEVEL_COUNT-1:0] pend_nxt; // Next pending levels.
   level_t                 lvl_r;    // Registered winning level.
   level_t                 lvl_nxt;  // Next winning level.
   logic                   vld_r;    // Registered verdict valid.
   logic                   vld_nxt;  // Next verdict valid.

   // Build the level vector and search from the highest number down; the lowest pending number wins.
   always_comb begin
      pend_nxt = '0;
      pend_nxt[LVL_EMULATION] = ev.fixed_ev[LVL_EMULATION]; // [R1]
      pend_nxt[LVL_RST]   = ev.fixed_ev[LVL_RST];            // [R1]
      pend_nxt[LVL_NMI]   = ev.fixed_ev[LVL_NMI];            // [R1]
      pend_nxt[LVL_EXC]   = ev.fixed_ev[LVL_EXC];            // [R1]
      // Level 4 is reserved and never pends.
      pend_nxt[LVL_HWERR] = ev.fixed_ev[LVL_HWERR] & ev.mask[LVL_HWERR]; // [R1]
      pend_nxt[LVL_CTMR]  = ev.fixed_ev[LVL_CTMR] & ev.mask[LVL_CTMR];   // [R1]
      pend_nxt[LEVEL_COUNT-1:GP_BASE] = ev.gp_req & ev.mask[LEVEL_COUNT-1:GP_BASE]; // [R1]
      lvl_nxt = '0;
      vld_nxt = |pend_nxt;
      // Walking downward lets the numerically lowest level overwrite the rest.
      for (int i = LEVEL_COUNT - 1; i >= 0; i--) begin
         if (pend_nxt[i]) begin
            lvl_nxt = level_t'(i);                           // [R12]
         end
      end
   end

   // Register the verdict.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_r <= '0;
         lvl_r  <= '0;
         vld_r  <= 1'b0;
      end else begin
         pend_r <= pend_nxt;
         lvl_r  <= lvl_nxt;
         vld_r  <= vld_nxt;
      end
   end

   assign ev.pending   = pend_r;
   assign ev.valid     = vld_r;
   assign ev.top_level = lvl_r;

   // No pending level may sit above the chosen one in priority.
   ord_lowest_a : assert property (@(posedge clk) disable iff (!rst_b) // [R12]
      vld_r |-> ((pend_r & ((16'h0001 << lvl_r) - 16'h0001)) == 16'h0000) && pend_r[lvl_r])
      else $error("Chosen level is not the highest priority pending one.");
   // The reserved level never shows as pending.
   rsv_level_a : assert property (@(posedge clk) disable iff (!rst_b) // [R1]
      !pend_r[LVL_RSV])
      else $error("Reserved level 4 became pending.");
   // Emulation lands at level 0 and wins over everything a cycle later.
   emulation_first_a : assert property (@(posedge clk) disable iff (!rst_b) // [R1]
      ev.fixed_ev[LVL_EMULATION] |=> vld_r && lvl_r == 4'h0)
      else $error("Emulation event was not taken as level 0.");
   // An enabled routed request for level 7 appears at level 7.
   gp_seven_a : assert property (@(posedge clk) disable iff (!rst_b) // [R1]
      ev.gp_req[0] && ev.mask[GP_BASE] |=> pend_r[GP_BASE])
      else $error("Level 7 request was not pending.");

   nmi_beats_gp_c : cover property (@(posedge clk) disable iff (!rst_b)
      ev.fixed_ev[LVL_NMI] && (|ev.gp_req) ##1 lvl_r == 4'h2);
   gp15_alone_c : cover property (@(posedge clk) disable iff (!rst_b)
      vld_r && lvl_r == 4'hF);
endmodule : core_event_ctrl
`default_nettype wire

// ===== rtl/system_irq_router.sv
// Purpose: Groups peripheral interrupts into IDs and routes each ID to one level.
// Assumes: Sources and routing writes are synchronous to clk.
// Notes:   Routing is written through a plain write port; reads return the stored code.
// Behaviour
// R1: Sixteen levels ordered emulation first, general last.
// R2: Each source reaches exactly one general level.
// R3: Default routing after reset; writes change it.
// R4: IDs 0 and 1 default to level 7.
// R5: ID 2 ORs all peripheral errors, level 7.
// R6: IDs 3 and 4 default to level 8.
// R7: IDs 5 to 8 default to level 9.
// R8: IDs 9 to 14 default to level 10.
// R9: IDs 15 to 18 default to level 11.
// R10: Timer IDs 19 to 26 default to level 12.
// R11: IDs 27 and 28 default to level 12.
// R12: Lower level number means higher priority.
// R13: Software keeps levels 14 and 15 for itself.
// R14: Shared ID requests are the OR of sources.
// R15: A level asserts while any routed ID is active.
`default_nettype none
module system_irq_router (
   input  wire logic                                        clk,
   input  wire logic                                        rst_b,
   input  wire logic [system_irq_router_pkg::SRC_COUNT-1:0] periph_src,
   input  wire logic                                        emulation_event,
   input  wire logic                                        reset_event,
   input  wire logic                                        nmi_event,
   input  wire logic                                        exception_event,
   input  wire logic                                        hardware_error_event,
   input  wire logic                                        core_timer_event,
   input  wire logic [15:0]                                 level_mask,
   input  wire logic                                        route_wr,
   input  wire system_irq_router_pkg::irq_id_t              route_wr_id,
   input  wire system_irq_router_pkg::gp_sel_t              route_wr_level,
   input  wire system_irq_router_pkg::irq_id_t              route_rd_id,
   output logic [3:0]                                       route_rd_level,
   output logic [system_irq_router_pkg::GP_COUNT-1:0]       gp_level,
   output logic [15:0]                                      event_pending,
   output logic                                             event_valid,
   output logic [3:0]                                       event_level
);
   import system_irq_router_pkg::*;

   // The tables and port widths must agree with the level space.
   // More than 32 IDs would also outgrow the five-bit ID ports.
   if (GP_BASE + GP_COUNT != LEVEL_COUNT || ID_COUNT > 32) begin : g_size_check
      $error("Router sizes do not match the level space.");
   end

   // Routing codes run from 0 for level 7 up to 8 for level 15.
   gp_sel_t             route_r   [ID_COUNT]; // Routing code per ID.
   gp_sel_t             route_nxt [ID_COUNT]; // Next routing codes.
   logic [ID_COUNT-1:0] id_req_r;             // Registered per-ID requests.
   logic [ID_COUNT-1:0] id_req_nxt;           // Next per-ID requests.
   logic [GP_COUNT-1:0] gp_r;                 // Registered level requests.
   logic [GP_COUNT-1:0] gp_nxt;               // Next level requests.
   gp_sel_t             rd_r;                 // Registered read-back code.
   gp_sel_t             rd_nxt;               // Next read-back code.
   logic                wr_ok;                // Write hits a real ID with a legal code.

   core_event_if ev ();

   // Latency, in edges after a source rises: the ID request registers on the
   // first, the level request on the second and the core verdict on the third.
   // Every stage is a register, so no pin reaches an output through logic
   // alone; three cycles of delay are cheap next to a handler's entry time.

   // Nothing here keeps software off levels 14 and 15; leaving them free for
   // software-raised handlers is the driver's job, so the logic stays simple.
   // A write naming an ID past 28 or a code above 8 is dropped whole, so a
   // bad write can never leave an ID pointing at no level at all.
   assign wr_ok = route_wr && (route_wr_id < irq_id_t'(ID_COUNT))
                  && (route_wr_level <= GP_SEL_MAX);

   // Gather sources into IDs, apply writes and fan IDs onto levels.
   always_comb begin
      // An ID is requested while any of its sources is high.
      id_req_nxt = '0;
      for (int s = 0; s < SRC_COUNT; s++) begin
         id_req_nxt[SRC_ID[s]] = id_req_nxt[SRC_ID[s]] | periph_src[s]; // [R14] [R5]
      end
      // The table holds its codes unless a legal write lands this cycle.
      route_nxt = route_r;
      if (wr_ok) begin
         // Only the addressed ID changes; its neighbours keep their codes.
         route_nxt[route_wr_id] = route_wr_level;                       // [R3]
      end
      // Levels start clear and each requested ID sets the one it points at.
      gp_nxt = '0;
      for (int i = 0; i < ID_COUNT; i++) begin
         // Each ID holds one code, so it lands on exactly one level.
         if (id_req_r[i]) begin
            gp_nxt[route_r[i]] = 1'b1;                                  // [R2] [R15]
         end
      end
      // An ID past the table reads back as code 0 rather than as stale data.
      rd_nxt = (route_rd_id < irq_id_t'(ID_COUNT)) ? route_r[route_rd_id] : '0;
   end

   // Register the routing table and the request pipeline.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         // Reset brings back the default routing, not an all-zero table.
         route_r  <= DFLT_ROUTE;                  // [R3] [R4] [R6] [R7] [R8] [R10] [R11]
         id_req_r <= '0;
         gp_r     <= '0;
         rd_r     <= '0;
      end else begin
         // Each stage moves one step per edge.
         route_r  <= route_nxt;
         id_req_r <= id_req_nxt;
         gp_r     <= gp_nxt;
         rd_r     <= rd_nxt;
      end
   end

   // Feed the core event control; level 4 input stays low as it is reserved.
   assign ev.gp_req   = gp_r;
   assign ev.fixed_ev = {core_timer_event, hardware_error_event, 1'b0, exception_event,
                         nmi_event, reset_event, emulation_event};   // [R1]
   assign ev.mask     = level_mask;

   // The core control orders the sixteen levels and reports the winner.
   core_event_ctrl core_event_ctrl_i (
      .clk   (clk),
      .rst_b (rst_b),
      .ev    (ev.ctrl)
   );

   // Outputs come straight from registers here and in the core control.
   assign gp_level       = gp_r;
   assign route_rd_level = rd_r;
   assign event_pending  = ev.pending;
   assign event_valid    = ev.valid;
   assign event_level    = ev.top_level;

   // Helper for the default checks: marks IDs that software has rewritten
   // since reset, so a legal write does not trip the default assertions.
   logic [ID_COUNT-1:0] written_r;   // IDs rewritten since reset.
   logic [ID_COUNT-1:0] written_nxt; // Next rewritten marks.

   // A refused write leaves the marks alone, as it leaves the table alone.
   always_comb begin
      written_nxt = written_r;
      if (wr_ok) begin
         // Only a write that was taken can move an ID off its default.
         written_nxt[route_wr_id] = 1'b1;
      end
   end

   // Register the marks; reset clears them together with the table.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         written_r <= '0;
      end else begin
         written_r <= written_nxt;
      end
   end

   // All checks below run on clk and rest while reset is low.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // While a group of IDs is unwritten since reset, its first and last codes are the defaults.
   dflt_level7_a : assert property (!(|written_r[2:0]) |-> // [R4] [R5]
      route_r[0] == 4'h0 && route_r[1] == 4'h0 && route_r[2] == 4'h0)
      else $error("IDs 0 to 2 left level 7 without a write.");
   dflt_level8_a : assert property (!(|written_r[4:3]) |-> // [R6]
      route_r[3] == 4'h1 && route_r[4] == 4'h1)
      else $error("IDs 3 and 4 left level 8 without a write.");
   dflt_level9_a : assert property (!(|written_r[8:5]) |-> // [R7]
      route_r[5] == 4'h2 && route_r[8] == 4'h2)
      else $error("IDs 5 to 8 left level 9 without a write.");
   dflt_level10_a : assert property (!(|written_r[14:9]) |-> // [R8]
      route_r[9] == 4'h3 && route_r[14] == 4'h3)
      else $error("IDs 9 to 14 left level 10 without a write.");
   dflt_level11_a : assert property (!(|written_r[18:15]) |-> // [R9]
      route_r[15] == 4'h4 && route_r[18] == 4'h4)
      else $error("IDs 15 to 18 left level 11 without a write.");
   dflt_level12_a : assert property (!(|written_r[28:19]) |-> // [R10] [R11]
      route_r[19] == 4'h5 && route_r[26] == 4'h5 && route_r[28] == 4'h5)
      else $error("IDs 19 to 28 left level 12 without a write.");

   // A legal write shows in the table one edge later.
   route_write_a : assert property (wr_ok |=> // [R3]
      route_r[$past(route_wr_id)] == $past(route_wr_level))
      else $error("Routing write did not take effect.");
   // One member of shared ID 1 is enough to raise the ID and then its level.
   share_or_a : assert property (periph_src[SRC_DMA_ERR] && !periph_src[0] |=> // [R14]
      id_req_r[1] ##1 gp_r[$past(route_r[1])])
      else $error("Shared ID 1 did not follow its source.");
   // With no ID active, every level drops on the next edge.
   gp_idle_a : assert property (!(|id_req_r) |=> gp_r == '0) // [R2] [R15]
      else $error("A level asserted with no active ID.");
   // Any one peripheral error raises ID 2 on the next edge.
   err_merge_a : assert property (|periph_src[13:6] |=> id_req_r[2]) // [R5] [R14]
      else $error("A peripheral error did not raise ID 2.");
   // With every source low, no ID may stay requested.
   id_quiet_a : assert property (!(|periph_src) |=> id_req_r == '0) // [R14]
      else $error("An ID stayed requested with no source high.");

   // The read port shows the code of the ID asked for one edge earlier.
   rd_back_a : assert property (route_rd_id < irq_id_t'(ID_COUNT) |=> // [R3]
      rd_r == $past(route_r[route_rd_id]))
      else $error("Read-back code does not match the table.");

   // Per ID: an active ID drives its level, and its code moves only on a write.
   for (genvar g = 0; g < ID_COUNT; g++) begin : g_route_chk
      gp_drive_a : assert property (id_req_r[g] |=> gp_r[$past(route_r[g])]) // [R15]
         else $error("Active ID did not drive its routed level.");
      // A refused write, or one aimed at another ID, leaves this code alone.
      route_hold_a : assert property (!(wr_ok && route_wr_id == irq_id_t'(g)) |=> // [R3]
         route_r[g] == $past(route_r[g]))
         else $error("Routing code changed without a legal write.");
   end

   // Scenarios worth seeing: a move to level 15, two errors at once, a timer win.
   reroute_c : cover property (wr_ok && route_wr_level == GP_SEL_MAX ##2 gp_r[8]);
   shared_id_c : cover property (periph_src[6] && periph_src[13]);
   timer_level_c : cover property (periph_src[32] ##3 event_level == 4'hC);
endmodule : system_irq_router
`default_nettype wire

// ===== bench/periph_model.sv
// Purpose: Stands in for the peripheral interrupt sources that sit beside the router.
// Assumes: Every source is a synchronous, active-high level on clk.
// Notes:   A request from the bench is launched one edge later, as a real peripheral would.
`default_nettype none
module periph_model (
   input  wire logic                                        clk,
   input  wire logic                                        rst_b,
   input  wire logic [system_irq_router_pkg::SRC_COUNT-1:0] src_cmd,
   output logic [system_irq_router_pkg::SRC_COUNT-1:0]      periph_src
);
   timeunit 1ns;
   timeprecision 1ps;
   import system_irq_router_pkg::*;
   logic [SRC_COUNT-1:0] src_r;    // Levels that the peripherals present.
   logic [SRC_COUNT-1:0] src_nxt;  // Levels for the next cycle.
   // Sources of a shared ID stay separate wires, so the router alone must merge them.
   always_comb begin
      src_nxt = src_cmd;
   end
   // A peripheral in reset raises nothing.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         src_r <= '0;
      end else begin
         src_r <= src_nxt;
      end
   end
   assign periph_src = src_r;
endmodule : periph_model
`default_nettype wire

// ===== bench/system_irq_router_bench.sv
// Purpose: Self-checking bench for the system interrupt router and its core event control.
// Assumes: Outputs are read once the levels have had four edges to settle.
// Notes:   Expected routing is worked out here from the ID ranges, not read from the design.
`default_nettype none
module system_irq_router_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import system_irq_router_pkg::*;
   logic                 clk = 1'b0;         // System clock, 4 ns period.
   logic                 rst_b = 1'b0;       // Asynchronous reset, active low.
   logic [SRC_COUNT-1:0] src_cmd = '0;       // Requests handed to the peripheral model.
   logic [SRC_COUNT-1:0] periph_src;         // Source levels from the model.
   logic [5:0]           fix_ev = 6'h00;     // Fixed events, levels 0, 1, 2, 3, 5, 6.
   logic [15:0]          level_mask = 16'hFFFF; // All levels enabled.
   logic                 route_wr = 1'b0;    // Routing write strobe.
   irq_id_t              route_wr_id = 5'h00; // Routing write target.
   gp_sel_t              route_wr_level = 4'h0; // Routing write code.
   irq_id_t              route_rd_id = 5'h00; // Routing read target.
   logic [3:0]           route_rd_level;     // Routing read answer.
   logic [GP_COUNT-1:0]  gp_level;           // Routed level requests.
   logic [15:0]          event_pending;      // Enabled pending levels.
   logic                 event_valid;        // Some level pends.
   logic [3:0]           event_level;        // Winning level.
   int                   fail_count = 0;     // Mismatches seen.
   int                   n_checks = 0;       // Comparisons made.
   int                   cycles = 0;         // Cycles since time zero.

   periph_model periph_model_i (.clk(clk), .rst_b(rst_b), .src_cmd(src_cmd),
      .periph_src(periph_src));
   system_irq_router system_irq_router_i (.clk(clk), .rst_b(rst_b), .periph_src(periph_src),
      .emulation_event(fix_ev[0]), .reset_event(fix_ev[1]), .nmi_event(fix_ev[2]),
      .exception_event(fix_ev[3]), .hardware_error_event(fix_ev[4]),
      .core_timer_event(fix_ev[5]), .level_mask(level_mask), .route_wr(route_wr),
      .route_wr_id(route_wr_id), .route_wr_level(route_wr_level), .route_rd_id(route_rd_id),
      .route_rd_level(route_rd_level), .gp_level(gp_level), .event_pending(event_pending),
      .event_valid(event_valid), .event_level(event_level));

   // Free-running clock.
   always #2 clk = ~clk;
   // A hang is cut short well beyond the few hundred cycles the tests need.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         report_and_stop();
      end
   end

   // Compares one value and reports a mismatch at once.
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Levels are steady four edges after the last input change.
   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask : settle
   // Default code by ID range, written out independently of the design tables.
   function automatic logic [3:0] dflt_code(input int id);
      if (id <= 2) return 4'h0;
      if (id <= 4) return 4'h1;
      if (id <= 8) return 4'h2;
      if (id <= 14) return 4'h3;
      if (id <= 18) return 4'h4;
      return 4'h5;
   endfunction : dflt_code
   // One-cycle routing write.
   task automatic write_route(input irq_id_t id, input gp_sel_t code);
      @(posedge clk);
      route_wr <= 1'b1;
      route_wr_id <= id;
      route_wr_level <= code;
      @(posedge clk);
      route_wr <= 1'b0;
   endtask : write_route
   // Reads one routing code and compares it.
   task automatic read_route(input irq_id_t id, input logic [3:0] exp);
      @(posedge clk);
      route_rd_id <= id;
      settle();
      check("route_rd_level", {12'h000, route_rd_level}, {12'h000, exp});
   endtask : read_route

   // Each source alone must light exactly its default level and win arbitration.
   task automatic default_routes();
      logic [3:0] code;
      for (int s = 0; s < SRC_COUNT; s++) begin
         @(posedge clk);
         src_cmd <= {{(SRC_COUNT-1){1'b0}}, 1'b1} << s;
         settle();
         code = dflt_code(int'(SRC_ID[s]));
         check("gp_level", {7'h00, gp_level}, 16'h0001 << code);
         check("event_level", {12'h000, event_level}, 16'h0007 + code);
         check("event_pending", event_pending, 16'h0080 << code);
      end
      @(posedge clk);
      src_cmd <= '0;
      settle();
      check("gp_level idle", {7'h00, gp_level}, 16'h0000);
      $display("default_routes finished");
   endtask : default_routes

   // Shared IDs stay requested while any member is high.
   task automatic shared_or();
      @(posedge clk);
      src_cmd <= 42'h00A;
      settle();
      check("gp_level two members", {7'h00, gp_level}, 16'h0001);
      @(posedge clk);
      src_cmd <= 42'h008;
      settle();
      check("gp_level one member", {7'h00, gp_level}, 16'h0001);
      @(posedge clk);
      src_cmd <= 42'h2000;
      settle();
      check("gp_level last error", {7'h00, gp_level}, 16'h0001);
      @(posedge clk);
      src_cmd <= '0;
      settle();
      check("gp_level released", {7'h00, gp_level}, 16'h0000);
      $display("shared_or finished");
   endtask : shared_or

   // Fixed events against a routed request: the lowest level number always wins.
   task automatic fixed_priority();
      logic [3:0] lv [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6};
      @(posedge clk);
      src_cmd <= 42'h001;
      for (int i = 5; i >= 0; i--) begin
         @(posedge clk);
         fix_ev <= 6'h3F << i;
         settle();
         check("event_level fixed", {12'h000, event_level}, {12'h000, lv[i]});
      end
      @(posedge clk);
      fix_ev <= 6'h00;
      level_mask <= 16'hFF7F;
      settle();
      check("event_valid masked", {15'h0000, event_valid}, 16'h0000);
      @(posedge clk);
      level_mask <= 16'hFFFF;
      src_cmd <= '0;
      $display("fixed_priority finished");
   endtask : fixed_priority

   // Rerouting, refused writes, and defaults coming back after a mid-run reset.
   task automatic reroute();
      write_route(5'h13, 4'h6);
      read_route(5'h13, 4'h6);
      write_route(5'h13, 4'h9);
      read_route(5'h13, 4'h6);
      write_route(5'h1D, 4'h0);
      read_route(5'h1D, 4'h0);
      @(posedge clk);
      src_cmd <= 42'h3_0000_0000;
      settle();
      check("gp_level rerouted", {7'h00, gp_level}, 16'h0060);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      read_route(5'h13, 4'h5);
      check("gp_level restored", {7'h00, gp_level}, 16'h0020);
      @(posedge clk);
      src_cmd <= '0;
      $display("reroute finished");
   endtask : reroute

   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // Main sequence.
   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      default_routes();
      shared_or();
      fixed_priority();
      reroute();
      report_and_stop();
   end
endmodule : system_irq_router_bench
`default_nettype wire
